// ### src/button_reset_defines.svh
// timing constants for the push-button reset supervisor
`ifndef BUTTON_RESET_DEFINES_SVH
`define BUTTON_RESET_DEFINES_SVH
`define CLK_PERIOD_NS 5
`define SETUP_SHORT_MS 2000
`define SETUP_MID_MS 6000
`define SETUP_LONG_MS 10000
`define RECOVERY_MS 200
`define DEBOUNCE_MS 240
`define MS_TO_CYCLES(ms) ((ms) * 64'd1000000 / `CLK_PERIOD_NS)
`endif

// ### src/button_reset_pkg.sv
// types for the push-button reset supervisor
package button_reset_pkg;
    typedef enum logic [1:0] {
        SEL_GROUND,
        SEL_OPEN,
        SEL_SUPPLY
    } delay_sel_e;
    typedef enum logic [1:0] {
        VAR_DUAL_CAP,
        VAR_DUAL_SEL,
        VAR_INSTANT,
        VAR_BATTERY
    } variant_e;
    typedef struct packed {
        logic drive;
        logic oe;
    } od_pin_s;
endpackage

// ### src/push_button_reset_delay.sv
// push-button reset supervisor with setup delay, pulse and instant reset
// Overview of operation
// - reset output is open drain, pulled low only while reset asserted
// - primary and secondary button inputs are asserted when low
// - dual-button variants need both buttons held beyond setup delay
// - reset asserts at once when setup delay met, releases after recovery
// - select pin picks 2 s ground, 6 s open, 10 s supply
// - capacitor variants take setup delay from timing capacitor pin
// - instant reset input is active high and needs no setup delay
// - instant input edge triggered; ignored until 240 ms after its fall
// - primary button and instant input act independently
// - battery variant has separate open-drain active-low battery low output
// - reset pulse length equals recovery period
// - battery variant only: undervoltage asserts reset and holds recovery period after recovery
// - closures shorter than setup delay cause no reset
`timescale 1ns/1ps
`include "button_reset_defines.svh"

module push_button_reset_delay
    import button_reset_pkg::*;
#(
    parameter variant_e VARIANT = VAR_DUAL_SEL,
    parameter int CW = 32,
    parameter logic [CW-1:0] SETUP_SHORT = CW'(`MS_TO_CYCLES(`SETUP_SHORT_MS)),
    parameter logic [CW-1:0] SETUP_MID = CW'(`MS_TO_CYCLES(`SETUP_MID_MS)),
    parameter logic [CW-1:0] SETUP_LONG = CW'(`MS_TO_CYCLES(`SETUP_LONG_MS)),
    parameter logic [CW-1:0] RECOVERY = CW'(`MS_TO_CYCLES(`RECOVERY_MS)),
    parameter logic [CW-1:0] DEBOUNCE = CW'(`MS_TO_CYCLES(`DEBOUNCE_MS))
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic primary_button_n,
    input wire logic secondary_button_n,
    input wire logic instant_reset_in,
    input wire logic delay_cap_pin,
    input wire logic [1:0] delay_select_pin,
    input wire logic supply_low,
    input wire logic battery_low_in,
    output logic reset_out,
    output logic reset_oe,
    output logic battery_low_n,
    output logic battery_low_oe
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [6:0] sync1;
    logic [6:0] sync2;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // idle pin levels, so no false instant edge follows reset
            sync1 <= 7'h07;
            sync2 <= 7'h07;
        end else if (clk_en) begin
            sync1 <= {battery_low_in, supply_low, delay_cap_pin, instant_reset_in,
                      secondary_button_n, primary_button_n, 1'b1};
            sync2 <= sync1;
        end
    end
    logic pb_n, sb_n, inst, cap_done, uv, batt;
    assign pb_n = sync2[1];
    assign sb_n = sync2[2];
    assign inst = sync2[3];
    assign cap_done = sync2[4];
    assign uv = sync2[5];
    assign batt = sync2[6];

    // select pin is static, so its own synchroniser suffices
    logic [1:0] sel1, sel2;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sel1 <= 2'h0;
            sel2 <= 2'h0;
        end else if (clk_en) begin
            sel1 <= delay_select_pin;
            sel2 <= sel1;
        end
    end

    // ----------------------------------------------------------------
    // setup delay timing
    // ----------------------------------------------------------------
    logic [CW-1:0] setup_limit;
    always_comb begin
        unique case (delay_sel_e'(sel2))
            SEL_GROUND: setup_limit = SETUP_SHORT;
            SEL_OPEN: setup_limit = SETUP_MID;
            SEL_SUPPLY: setup_limit = SETUP_LONG;
            default: setup_limit = SETUP_MID;
        endcase
    end

    logic dual, buttons_held;
    assign dual = (VARIANT != VAR_INSTANT);
    assign buttons_held = !pb_n && (!dual || !sb_n);

    logic [CW-1:0] setup_cnt;
    logic armed;
    logic setup_met;
    // cap variants: the external ramp comparator reports expiry
    assign setup_met = buttons_held && armed &&
        ((VARIANT == VAR_DUAL_CAP || VARIANT == VAR_BATTERY) ? cap_done
                                                              : (setup_cnt >= setup_limit));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            setup_cnt <= '0;
            armed <= 1'b1;
        end else if (clk_en) begin
            if (!buttons_held) begin
                setup_cnt <= '0;
                armed <= 1'b1;
            end else if (setup_met) begin
                armed <= 1'b0; // one pulse per hold
            end else if (setup_cnt != '1) begin
                setup_cnt <= setup_cnt + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // instant input edge and debounce
    // ----------------------------------------------------------------
    logic inst_d, inst_rise, inst_fall, inst_lock;
    logic [CW-1:0] deb_cnt;
    assign inst_rise = inst && !inst_d;
    assign inst_fall = !inst && inst_d;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            inst_d <= 1'b0;
        end else if (clk_en) begin
            inst_d <= inst;
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            inst_lock <= 1'b0;
            deb_cnt <= '0;
        end else if (clk_en) begin
            if (inst_rise && !inst_lock) begin
                inst_lock <= 1'b1;
                deb_cnt <= '0;
            end else if (inst_lock) begin
                // lockout restarts at every fall, so bounce is absorbed
                if (inst || inst_fall) begin
                    deb_cnt <= '0;
                end else if (deb_cnt >= DEBOUNCE - 1'b1) begin
                    inst_lock <= 1'b0;
                end else begin
                    deb_cnt <= deb_cnt + 1'b1;
                end
            end
        end
    end
    logic inst_trig;
    assign inst_trig = (VARIANT == VAR_INSTANT) && inst_rise && !inst_lock;

    // ----------------------------------------------------------------
    // reset pulse
    // ----------------------------------------------------------------
    logic uv_mon;
    assign uv_mon = (VARIANT == VAR_BATTERY) && uv;
    logic rst_active;
    logic [CW-1:0] rec_cnt;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_active <= 1'b1;
            rec_cnt <= '0;
        end else if (clk_en) begin
            if (setup_met || inst_trig || uv_mon) begin
                rst_active <= 1'b1;
                rec_cnt <= '0;
            end else if (rst_active) begin
                if (rec_cnt >= RECOVERY - 1'b1) begin
                    rst_active <= 1'b0;
                end else begin
                    rec_cnt <= rec_cnt + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // open-drain outputs
    // ----------------------------------------------------------------
    assign reset_out = 1'b0;
    assign reset_oe = rst_active;
    assign battery_low_n = 1'b0;
    assign battery_low_oe = (VARIANT == VAR_BATTERY) && batt;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_short_hold_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        (!rst_active && !buttons_held && clk_en) |=> !setup_met)
        else $error("setup met without buttons held");
    a_setup_fires_rst: assert property (@(posedge mclk) disable iff (!resetn)
        (setup_met && clk_en) |=> reset_oe)
        else $error("reset not asserted after setup");
    a_release_clears: assert property (@(posedge mclk) disable iff (!resetn)
        (!buttons_held && clk_en) |=> setup_cnt == '0)
        else $error("setup count not cleared");
    a_instant_fires: assert property (@(posedge mclk) disable iff (!resetn)
        (inst_trig && clk_en) |=> reset_oe && inst_lock)
        else $error("instant reset missed");
    a_lock_blocks: assert property (@(posedge mclk) disable iff (!resetn)
        (inst_lock && (inst || inst_fall) && clk_en) |=> inst_lock && deb_cnt == '0)
        else $error("lockout released while instant input active");
    a_pulse_ends: assert property (@(posedge mclk) disable iff (!resetn)
        (rst_active && clk_en && rec_cnt >= RECOVERY - 1'b1 && !setup_met && !inst_trig && !uv_mon)
        |=> !reset_oe)
        else $error("reset pulse too long");
    a_od_drive: assert property (@(posedge mclk) disable iff (!resetn)
        reset_out == 1'b0 && (reset_oe == rst_active))
        else $error("reset pin not open drain");
    a_uv_holds: assert property (@(posedge mclk) disable iff (!resetn)
        (uv_mon && clk_en) |=> reset_oe && rec_cnt == '0)
        else $error("undervoltage did not hold reset");
    a_dual_needs: assert property (@(posedge mclk) disable iff (!resetn)
        (dual && sb_n) |-> !setup_met)
        else $error("single button fired dual variant");
    c_setup_reset: cover property (@(posedge mclk) disable iff (!resetn) setup_met);
    c_instant_reset: cover property (@(posedge mclk) disable iff (!resetn) inst_trig);
    c_pulse_end: cover property (@(posedge mclk) disable iff (!resetn) $fell(rst_active));
    c_lock_release: cover property (@(posedge mclk) disable iff (!resetn) $fell(inst_lock));

endmodule // push_button_reset_delay

// ### verification/button_host_model.sv
// model of the two push buttons and the host reset input
`timescale 1ns/1ps

module button_host_model (
    input wire logic press0,
    input wire logic press1,
    input wire logic reset_out,
    input wire logic reset_oe,
    input wire logic battery_low_n,
    input wire logic battery_low_oe,
    output logic primary_button_n,
    output logic secondary_button_n,
    output logic host_reset_n,
    output logic battery_line_n
);
    // ------------------------------
    // switches and reset wire
    // ------------------------------
    // a released switch leaves its pin on the pull-up
    assign primary_button_n = press0 ? 1'b0 : 1'b1;
    assign secondary_button_n = press1 ? 1'b0 : 1'b1;
    // host input has a pull-up; only the device pulls it low
    assign host_reset_n = reset_oe ? reset_out : 1'b1;
    // battery low wire has only a board pull-up
    assign battery_line_n = battery_low_oe ? battery_low_n : 1'b1;
endmodule // button_host_model

// ### verification/tb_push_button_reset_delay.sv
// self-checking testbench for the push-button reset supervisor
`timescale 1ns/1ps

module tb_push_button_reset_delay;
    import button_reset_pkg::*;
    // ------------------------------
    // setup
    // ------------------------------
    // shortened counts keep the run brief
    localparam int LIM [3] = '{20, 60, 100};
    localparam int REC = 10;
    localparam int DEB = 15;
    localparam logic [31:0] SET_S = 32'h14;
    localparam logic [31:0] SET_M = 32'h3C;
    localparam logic [31:0] SET_L = 32'h64;
    localparam logic [31:0] REC_C = 32'hA;
    localparam logic [31:0] DEB_C = 32'hF;
    // line 0 select-delay pair, line 1 instant input, line 2 capacitor with battery
    localparam variant_e VARS [3] = '{VAR_DUAL_SEL, VAR_INSTANT, VAR_BATTERY};
    logic mclk, resetn, press0, press1, en, inst_in, cap, uv, batt;
    logic [1:0] sel;
    wire [2:0] ro, roe, bl, bloe, b0_n, b1_n, host_n, bl_line;
    int fails, num_checks;

    for (genvar v = 0; v < 3; v++) begin : g_var
        push_button_reset_delay #(.VARIANT(VARS[v]), .SETUP_SHORT(SET_S), .SETUP_MID(SET_M), .SETUP_LONG(SET_L),
            .RECOVERY(REC_C), .DEBOUNCE(DEB_C)) push_button_reset_delay_inst (
            .mclk(mclk), .resetn(resetn), .clk_en(en), .primary_button_n(b0_n[v]), .secondary_button_n(b1_n[v]),
            .instant_reset_in(inst_in), .delay_cap_pin(cap), .delay_select_pin(sel), .supply_low(uv),
            .battery_low_in(batt), .reset_out(ro[v]), .reset_oe(roe[v]), .battery_low_n(bl[v]),
            .battery_low_oe(bloe[v]));

        button_host_model button_host_model_inst (.press0(press0), .press1(press1), .reset_out(ro[v]),
            .reset_oe(roe[v]), .battery_low_n(bl[v]), .battery_low_oe(bloe[v]), .primary_button_n(b0_n[v]),
            .secondary_button_n(b1_n[v]), .host_reset_n(host_n[v]), .battery_line_n(bl_line[v]));
    end

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic end_of_test();
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // waits at most lim edges for host line k to reach lvl
    task automatic wait_lvl(input int k, input logic lvl, input int lim);
        for (int i = 0; i < lim && host_n[k] !== lvl; i++) @(posedge mclk);
    endtask

    // counts the edges for which host line k stays low
    task automatic low_len(input int k, output int n);
        n = 0;
        while (host_n[k] === 1'b0 && n < 50) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    // select only changes while held in reset
    task automatic restart(input int s);
        @(posedge mclk);
        sel <= 2'(s);
        press0 <= 1'b0;
        press1 <= 1'b0;
        en <= 1'b1;
        inst_in <= 1'b0;
        cap <= 1'b0;
        uv <= 1'b0;
        batt <= 1'b0;
        resetn <= 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        wait_lvl(0, 1'b1, REC + 4);
        chk(host_n, 3'h7);
    endtask

    task automatic hold_both(input int s);
        int n;
        restart(s);
        press0 <= 1'b1;
        press1 <= 1'b1;
        repeat (LIM[s] - 1) @(posedge mclk);
        chk(host_n[0], 1'b1);
        wait_lvl(0, 1'b0, 8);
        chk(host_n[0], 1'b0);
        low_len(0, n);
        chk_n(n, REC);
    endtask

    task automatic one_button();
        restart(0);
        press0 <= 1'b1;
        wait_lvl(1, 1'b0, LIM[0] + 8);
        chk(host_n[1], 1'b0);
        repeat (3 * LIM[0]) @(posedge mclk);
        chk(host_n[1:0], 2'h3);
        press1 <= 1'b1;
        wait_lvl(0, 1'b0, LIM[0] + 8);
        chk(host_n[0], 1'b0);
    endtask

    task automatic early_release();
        restart(0);
        press0 <= 1'b1;
        press1 <= 1'b1;
        repeat (15) @(posedge mclk);
        press1 <= 1'b0;
        repeat (3) @(posedge mclk);
        press1 <= 1'b1;
        repeat (15) @(posedge mclk);
        chk(host_n[0], 1'b1);
        wait_lvl(0, 1'b0, 15);
        chk(host_n[0], 1'b0);
    endtask

    // rise, level held, bounce inside the lockout, then a clean rise after it
    task automatic instant_edge();
        restart(0);
        inst_in <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(host_n[1], 1'b0);
        repeat (REC + 6) @(posedge mclk);
        chk(host_n[1], 1'b1);
        inst_in <= 1'b0;
        repeat (6) @(posedge mclk);
        inst_in <= 1'b1;
        repeat (4) @(posedge mclk);
        inst_in <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(host_n[1], 1'b1);
        repeat (DEB + 4) @(posedge mclk);
        inst_in <= 1'b1;
        wait_lvl(1, 1'b0, 6);
        chk(host_n[1], 1'b0);
        inst_in <= 1'b0;
    endtask

    // capacitor ramp, battery low wire and undervoltage hold
    task automatic battery_var();
        int n;
        restart(0);
        press0 <= 1'b1;
        press1 <= 1'b1;
        repeat (LIM[0] + 6) @(posedge mclk);
        chk(host_n[2], 1'b1);
        cap <= 1'b1;
        wait_lvl(2, 1'b0, 6);
        chk(host_n[2], 1'b0);
        repeat (REC + 2) @(posedge mclk);
        press0 <= 1'b0;
        press1 <= 1'b0;
        cap <= 1'b0;
        batt <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(bl_line, 3'h3);
        chk(host_n[2], 1'b1);
        batt <= 1'b0;
        uv <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(bl_line, 3'h7);
        repeat (17) @(posedge mclk);
        chk(host_n, 3'h3);
        uv <= 1'b0;
        low_len(2, n);
        chk_n(n, REC + 3);
    endtask

    // a low clock enable must stretch the setup count by the frozen span
    task automatic freeze_hold();
        restart(0);
        press0 <= 1'b1;
        press1 <= 1'b1;
        repeat (10) @(posedge mclk);
        en <= 1'b0;
        repeat (20) @(posedge mclk);
        chk(host_n, 3'h7);
        en <= 1'b1;
        repeat (10) @(posedge mclk);
        chk(host_n[0], 1'b1);
        wait_lvl(0, 1'b0, 8);
        chk(host_n[0], 1'b0);
    endtask

    initial begin
        resetn = 1'b0;
        press0 = 1'b0;
        press1 = 1'b0;
        en = 1'b1;
        inst_in = 1'b0;
        cap = 1'b0;
        uv = 1'b0;
        batt = 1'b0;
        sel = 2'h0;
        fails = 0;
        num_checks = 0;
        for (int s = 0; s < 3; s++) hold_both(s);
        one_button();
        early_release();
        instant_edge();
        battery_var();
        freeze_hold();
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        end_of_test();
    end
endmodule // tb_push_button_reset_delay
